/* rtl/ioexp_pkg.sv */
package ioexp_pkg;

  // port width
  localparam int unsigned IOEXP_W = 8;

  // register pointer codes
  localparam logic [1:0] IOEXP_REG_INPUT_LEVELS = 2'h0;
  localparam logic [1:0] IOEXP_REG_OUTPUT_LEVELS = 2'h1;
  localparam logic [1:0] IOEXP_REG_INPUT_INVERSION = 2'h2;
  localparam logic [1:0] IOEXP_REG_PIN_DIRECTION = 2'h3;

  // reset values
  localparam logic [7:0] IOEXP_OUTPUT_LEVELS_RST = 8'hFF;
  localparam logic [7:0] IOEXP_INPUT_INVERSION_RST = 8'h00;
  localparam logic [7:0] IOEXP_PIN_DIRECTION_RST = 8'hFF;
  localparam logic [7:0] IOEXP_INPUT_LEVELS_RST = 8'h00;

  // fixed upper five bits of the seven-bit bus address
  localparam logic [4:0] IOEXP_ADDR_FIXED = 5'h10;

  // bits per byte on the bus and command field position
  localparam logic [3:0] IOEXP_BITS_PER_BYTE = 4'h8;
  localparam int unsigned IOEXP_CMD_CODE_W = 2;

  // fastest serial clock accepted, and sampling clock
  localparam int unsigned IOEXP_SCL_MAX_HZ = 400_000;
  localparam int unsigned IOEXP_CLK_HZ = 250_000_000;
  localparam int unsigned IOEXP_SCL_MIN_CYCLES =
    IOEXP_CLK_HZ / IOEXP_SCL_MAX_HZ;

  typedef enum logic [3:0] {
    IOEXP_ST_IDLE,
    IOEXP_ST_ADDR,
    IOEXP_ST_ADDR_ACK,
    IOEXP_ST_CMD,
    IOEXP_ST_CMD_ACK,
    IOEXP_ST_WDATA,
    IOEXP_ST_WDATA_ACK,
    IOEXP_ST_RDATA,
    IOEXP_ST_RDATA_ACK
  } ioexp_state_e;

endpackage

/* rtl/ioexp_top.sv */
`timescale 1ns/1ps

// Behaviour
// - eight-bit direction register picks input or output per pin
// - captured pin levels and drive levels kept in separate registers
// - inversion register flips the read sense of each input bit
// - all four registers can be read back by the bus master
// - alert pulled low while any input differs from its captured level
// - power-up loads register defaults and idles the bus state machine
// - low reset pin gives the same initialisation without power loss
// - two strap pins set the low address bits, four devices per bus
// - after any reset all eight pins are inputs
// - first byte after a write address is stored as register pointer
// - code 0 read-only input levels; codes 1 to 3 read-write
// - bus works from static up to 400 kHz serial clock
// - alert released when input returns or input levels are read
// - direction 1 means high-impedance input, 0 drives output level
// - output reads return flip-flops; writes to input levels ignored
// - inversion bit 1 inverts the input bit, 0 leaves it
module ioexp_top
  import ioexp_pkg::*;
#(
  parameter logic [4:0] ADDR_FIXED = IOEXP_ADDR_FIXED,
  parameter int unsigned W = IOEXP_W
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic reset_pin_n_i, // device reset pin, active low
  input wire logic scl_i, // serial clock line level
  input wire logic sda_i, // serial data line level
  output logic sda_o, // data line drive value, always low
  output logic sda_oe_o, // high while pulling data line low
  input wire logic addr_strap_low_i, // address strap bit 0
  input wire logic addr_strap_high_i, // address strap bit 1
  input wire logic [W-1:0] port_pin_i, // port pin levels
  output logic [W-1:0] port_pin_o, // port pin drive values
  output logic [W-1:0] port_pin_oe_o, // high where a pin is an output
  output logic change_alert_o, // alert drive value, always low
  output logic change_alert_oe_o // high while alert is pulled low
);

  // serial line samples for edge detection
  logic scl_q;
  logic sda_q;

  // bus engine state
  ioexp_state_e st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [1:0] ptr_q;
  // master refused the last read byte
  logic nack_q;
  logic sda_oe_q;

  // register file
  logic [W-1:0] input_levels_q;
  logic [W-1:0] output_levels_q;
  logic [W-1:0] input_inversion_q;
  logic [W-1:0] pin_direction_q;
  // one-cycle flag that captures the pins right after a reset
  logic init_q;

  // pin side flops
  logic [W-1:0] pin_oe_q;
  logic alert_oe_q;
  logic zero_q;

  // bus events, oversampled at the system clock
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic byte_done;
  logic addr_hit;
  logic cmd_ok;
  logic ack_c;
  logic rx_state;
  logic ld_rd;
  logic wr_stb;
  logic cap_c;
  logic soft_rst;
  logic [W-1:0] rd_byte;
  logic [W-1:0] mismatch;
  ioexp_state_e ack_st;

  // register read mux
  function automatic logic [W-1:0] reg_read(
    input logic [1:0] ptr,
    input logic [W-1:0] pins,
    input logic [W-1:0] outs,
    input logic [W-1:0] inv,
    input logic [W-1:0] dir
  );
    logic [W-1:0] r;
    r = '0;
    unique case (ptr)
      IOEXP_REG_INPUT_LEVELS: r = pins ^ inv;
      IOEXP_REG_OUTPUT_LEVELS: r = outs;
      IOEXP_REG_INPUT_INVERSION: r = inv;
      IOEXP_REG_PIN_DIRECTION: r = dir;
    endcase
    return r;
  endfunction

  // 250 MHz oversampling covers any bus clock up to fast mode
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_done = scl_fall && (bit_cnt_q == IOEXP_BITS_PER_BYTE);
  // the reset pin acts as a synchronous clear of the block, except the scl_q and sda_q line samples
  assign soft_rst = ~reset_pin_n_i;

  assign addr_hit = rx_q[7:1] ==
    {ADDR_FIXED, addr_strap_high_i, addr_strap_low_i};
  assign cmd_ok = rx_q[7:IOEXP_CMD_CODE_W] == '0;

  assign rx_state = (st_q == IOEXP_ST_ADDR) || (st_q == IOEXP_ST_CMD) ||
    (st_q == IOEXP_ST_WDATA);
  assign ack_c = rx_state && ((st_q == IOEXP_ST_ADDR) ? addr_hit :
    (st_q == IOEXP_ST_CMD) ? cmd_ok : 1'b1);
  assign ack_st = (st_q == IOEXP_ST_ADDR) ? IOEXP_ST_ADDR_ACK :
    (st_q == IOEXP_ST_CMD) ? IOEXP_ST_CMD_ACK : IOEXP_ST_WDATA_ACK;

  // a read byte is loaded at the fall that ends an acknowledge
  assign ld_rd = scl_fall &&
    (((st_q == IOEXP_ST_ADDR_ACK) && rx_q[0]) ||
     ((st_q == IOEXP_ST_RDATA_ACK) && !nack_q));
  assign wr_stb = (st_q == IOEXP_ST_WDATA) && byte_done;
  // an input-level read recaptures the pins and so clears the alert
  assign cap_c = ld_rd && (ptr_q == IOEXP_REG_INPUT_LEVELS);

  // read value is taken into the shifter when the byte is loaded
  assign rd_byte = reg_read(ptr_q, port_pin_i, output_levels_q,
    input_inversion_q, pin_direction_q);

  // inputs that have moved away from the captured level
  // output pins are masked, so driving them never raises the alert
  assign mismatch = (port_pin_i ^ input_levels_q) & pin_direction_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // bus engine
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= IOEXP_ST_IDLE;
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      ptr_q <= IOEXP_REG_INPUT_LEVELS;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (soft_rst) begin
      st_q <= IOEXP_ST_IDLE;
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      ptr_q <= IOEXP_REG_INPUT_LEVELS;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      // a start restarts the engine even in the middle of a byte
      st_q <= IOEXP_ST_ADDR;
      bit_cnt_q <= '0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= IOEXP_ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (ld_rd) begin
      st_q <= IOEXP_ST_RDATA;
      bit_cnt_q <= '0;
      sda_oe_q <= ~rd_byte[7];
      tx_q <= {rd_byte[6:0], 1'b0};
    end else begin
      unique case (st_q)
        IOEXP_ST_IDLE: begin
          // bus idle or refused: keep the data line released
          sda_oe_q <= 1'b0;
        end
        IOEXP_ST_ADDR, IOEXP_ST_CMD, IOEXP_ST_WDATA: begin
          if (scl_rise) begin
            rx_q <= {rx_q[6:0], sda_i};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            bit_cnt_q <= '0;
            if (st_q == IOEXP_ST_CMD) begin
              // pointer keeps its low bits even for a refused code
              ptr_q <= rx_q[1:0];
            end
            if (ack_c) begin
              sda_oe_q <= 1'b1;
              st_q <= ack_st;
            end else begin
              st_q <= IOEXP_ST_IDLE;
            end
          end
        end
        IOEXP_ST_ADDR_ACK, IOEXP_ST_CMD_ACK, IOEXP_ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            st_q <= (st_q == IOEXP_ST_ADDR_ACK) ? IOEXP_ST_CMD :
              IOEXP_ST_WDATA;
          end
        end
        IOEXP_ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            bit_cnt_q <= '0;
            sda_oe_q <= 1'b0;
            st_q <= IOEXP_ST_RDATA_ACK;
          end else if (scl_fall) begin
            sda_oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        IOEXP_ST_RDATA_ACK: begin
          // pointer stays, so a further byte re-reads the same register
          if (scl_rise) begin
            nack_q <= sda_i;
          end else if (scl_fall) begin
            st_q <= IOEXP_ST_IDLE;
          end
        end
      endcase
    end
  end

  // register file
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      output_levels_q <= IOEXP_OUTPUT_LEVELS_RST;
      input_inversion_q <= IOEXP_INPUT_INVERSION_RST;
      pin_direction_q <= IOEXP_PIN_DIRECTION_RST;
      input_levels_q <= IOEXP_INPUT_LEVELS_RST;
      init_q <= 1'b1;
    end else if (soft_rst) begin
      output_levels_q <= IOEXP_OUTPUT_LEVELS_RST;
      input_inversion_q <= IOEXP_INPUT_INVERSION_RST;
      pin_direction_q <= IOEXP_PIN_DIRECTION_RST;
      input_levels_q <= IOEXP_INPUT_LEVELS_RST;
      init_q <= 1'b1;
    end else begin
      // capture after reset, and again on every input-level read
      if (init_q || cap_c) begin
        input_levels_q <= port_pin_i;
      end
      init_q <= 1'b0;
      // writes to code 0 are acknowledged and dropped
      if (wr_stb) begin
        unique case (ptr_q)
          IOEXP_REG_INPUT_LEVELS: ;
          IOEXP_REG_OUTPUT_LEVELS: output_levels_q <= rx_q;
          IOEXP_REG_INPUT_INVERSION: input_inversion_q <= rx_q;
          IOEXP_REG_PIN_DIRECTION: pin_direction_q <= rx_q;
        endcase
      end
    end
  end

  // pin drivers and change alert
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      alert_oe_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (soft_rst) begin
      alert_oe_q <= 1'b0;
      zero_q <= 1'b0;
    end else begin
      // a pin turned from output to input may raise a stale alert
      alert_oe_q <= ~init_q & ~soft_rst & (|mismatch);
      zero_q <= 1'b0;
    end
  end

  // drive enables, cleared by the reset pin without waiting a cycle
  for (genvar g = 0; g < W; g++) begin : g_pin_oe
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        pin_oe_q[g] <= 1'b0;
      end else if (soft_rst) begin
        pin_oe_q[g] <= 1'b0;
      end else begin
        pin_oe_q[g] <= ~pin_direction_q[g];
      end
    end
  end

  assign sda_o = zero_q;
  assign sda_oe_o = sda_oe_q;
  assign port_pin_o = output_levels_q;
  assign port_pin_oe_o = pin_oe_q;
  assign change_alert_o = zero_q;
  assign change_alert_oe_o = alert_oe_q;

endmodule

/* tb/ioexp_top_asserts.sv */
`timescale 1ns/1ps
module ioexp_top_chk (
  input wire logic clock_i, // clock
  input wire logic rst_i, // reset
  input wire logic reset_pin_n_i, // reset pin
  input wire logic scl_i, // clock line
  input wire logic sda_o, // data drive
  input wire logic sda_oe_o, // data enable
  input wire logic [7:0] port_pin_i, // pins in
  input wire logic [7:0] port_pin_o, // pins out
  input wire logic [7:0] port_pin_oe_o, // pin enables
  input wire logic change_alert_o, // alert drive
  input wire logic change_alert_oe_o // alert enable
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sda_open_drain_a: assert property (sda_o == 1'b0)
    else $error("data drive not low");
  alert_open_drain_a: assert property (change_alert_o == 1'b0)
    else $error("alert drive not low");
  pin_reset_a: assert property (!reset_pin_n_i [*2] |->
    port_pin_o == 8'hFF && port_pin_oe_o == 8'h00 && !sda_oe_o)
    else $error("defaults not held in reset");
  alert_quiet_a: assert property (($stable(port_pin_i) && scl_i &&
    reset_pin_n_i) [*4] |-> $stable(change_alert_oe_o))
    else $error("alert moved without cause");
  ack_rise_a: assert property ($rose(sda_oe_o) |->
    !scl_i && !$past(scl_i)) else $error("data driven early");
  ack_fall_a: assert property ($fell(sda_oe_o) |->
    !$past(scl_i) || !$past(reset_pin_n_i)) else $error("data release");
  out_update_a: assert property ($changed(port_pin_o) |->
    !$past(scl_i) || !$past(reset_pin_n_i)) else $error("output moved");
  dir_update_a: assert property ($changed(port_pin_oe_o) |->
    !$past(scl_i, 2) || !$past(reset_pin_n_i)) else $error("dir moved");
endmodule
bind ioexp_top ioexp_top_chk ioexp_top_chk_i (.clock_i(clock_i),
  .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .port_pin_i(port_pin_i),
  .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
  .change_alert_o(change_alert_o), .change_alert_oe_o(change_alert_oe_o));

/* tb/ioexp_master.sv */
`timescale 1ns/1ps
module ioexp_master #(
  parameter int PH = 8
) (
  input wire logic clk_i, // system clock
  input wire logic sda_i, // resolved data line
  output logic scl_pull_o, // high pulls clock line low
  output logic sda_pull_o // high pulls data line low
);
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic start();
    sda_pull_o <= 1'b1;
    wt(PH);
    scl_pull_o <= 1'b1;
    wt(PH / 2);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_pull_o <= ~b;
    wt(PH / 2);
    scl_pull_o <= 1'b0;
    wt(PH);
    r = sda_i;
    scl_pull_o <= 1'b1;
    wt(PH / 2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak,
    output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ak, a);
  endtask
  task automatic stop();
    sda_pull_o <= 1'b1;
    wt(PH / 2);
    scl_pull_o <= 1'b0;
    wt(PH);
    sda_pull_o <= 1'b0;
    wt(PH);
  endtask
endmodule

/* tb/ioexp_top_tb.sv */
`timescale 1ns/1ps
module ioexp_top_tb;
  import ioexp_pkg::*;
  logic clock_i, rst_i, rst_n, scl_pull, sda_pull, sda_oe, alert_oe;
  logic [1:0] strap;
  logic [6:0] dev;
  logic [7:0] ext, pin_o, pin_oe, pins, q;
  logic [2:0] a;
  wire scl = ~scl_pull;
  wire sda = ~(sda_pull | sda_oe);
  int bad_count, cmp_count;
  assign dev = {IOEXP_ADDR_FIXED, strap};
  assign pins = (pin_oe & pin_o) | (~pin_oe & ext);
  ioexp_top ioexp_top_i (.clock_i(clock_i), .rst_i(rst_i),
    .reset_pin_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .addr_strap_low_i(strap[0]),
    .addr_strap_high_i(strap[1]), .port_pin_i(pins), .port_pin_o(pin_o),
    .port_pin_oe_o(pin_oe), .change_alert_o(), .change_alert_oe_o(alert_oe));
  ioexp_master ioexp_master_i (.clk_i(clock_i), .sda_i(sda),
    .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] c, d);
    ioexp_master_i.start();
    ioexp_master_i.xfer({ad, 1'b0}, 1'b1, q, a[2]);
    ioexp_master_i.xfer(c, 1'b1, q, a[1]);
    ioexp_master_i.xfer(d, 1'b1, q, a[0]);
    ioexp_master_i.stop();
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic n;
    ioexp_master_i.start();
    ioexp_master_i.xfer({dev, 1'b0}, 1'b1, q, a[2]);
    ioexp_master_i.xfer(c, 1'b1, q, a[1]);
    ioexp_master_i.stop();
    ioexp_master_i.start();
    ioexp_master_i.xfer({dev, 1'b1}, 1'b1, q, a[0]);
    ioexp_master_i.xfer(8'hFF, 1'b1, q, n);
    ioexp_master_i.stop();
    chk({5'h0, a}, 8'h00);
    chk({7'h0, n}, 8'h01);
    chk(q, exp);
  endtask
  task automatic t_defaults();
    chk(pin_o, 8'hFF);
    chk(pin_oe, 8'h00);
    rd(8'h03, 8'hFF);
    rd(8'h01, 8'hFF);
    rd(8'h02, 8'h00);
  endtask
  task automatic t_regs();
    wr(dev, 8'h01, 8'h5A);
    chk({5'h0, a}, 8'h00);
    wr(dev, 8'h02, 8'h0F);
    wr(dev, 8'h03, 8'hF0);
    rd(8'h01, 8'h5A);
    rd(8'h02, 8'h0F);
    rd(8'h03, 8'hF0);
    chk(pin_o, 8'h5A);
    chk(pin_oe, 8'h0F);
    rd(8'h00, {ext[7:4], 4'hA} ^ 8'h0F);
  endtask
  task automatic t_refuse();
    wr(dev, 8'h00, 8'h00);
    chk({5'h0, a}, 8'h00);
    rd(8'h00, {ext[7:4], 4'hA} ^ 8'h0F);
    wr(dev, 8'h04, 8'h00);
    chk({5'h0, a}, 8'h03);
    strap <= 2'b01;
    wr({IOEXP_ADDR_FIXED, 2'b10}, 8'h01, 8'h00);
    chk({5'h0, a}, 8'h07);
    strap <= 2'b10;
    @(posedge clock_i);
    rd(8'h01, 8'h5A);
  endtask
  task automatic t_alert();
    ext <= ext ^ 8'h80;
    repeat (4) @(posedge clock_i);
    chk({7'h0, alert_oe}, 8'h01);
    ext <= ext ^ 8'h80;
    repeat (4) @(posedge clock_i);
    chk({7'h0, alert_oe}, 8'h00);
    ext <= ext ^ 8'h80;
    repeat (4) @(posedge clock_i);
    chk({7'h0, alert_oe}, 8'h01);
    rd(8'h00, {ext[7:4], 4'hA} ^ 8'h0F);
    chk({7'h0, alert_oe}, 8'h00);
  endtask
  task automatic t_pin_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk(pin_oe, 8'h00);
    rst_n <= 1'b1;
    @(posedge clock_i);
    rd(8'h03, 8'hFF);
    rd(8'h01, 8'hFF);
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    bad_count++;
    summarize();
  end
  initial begin
    rst_i = 1'b1;
    rst_n = 1'b1;
    strap = 2'b10;
    ext = 8'hC3;
    bad_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_defaults();
    t_regs();
    t_refuse();
    t_alert();
    t_pin_reset();
    summarize();
  end
endmodule
